// ---- src/counter_pkg.sv ----
package counter_pkg;

	localparam int COUNT_W = 16;
	localparam int LEN_W = 33;
	localparam int CTRL_W = 4;
	localparam int EV_W = 5;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int CHANNELS = 2;

	// Timing
	localparam longint unsigned CLOCK_HZ = 64'd200000000;
	localparam longint unsigned MIN_SHORT_MS = 64'd100;
	localparam longint unsigned MIN_LONG_MS = 64'd350;
	localparam longint unsigned MAX_HIGH_MS = 64'd30000;
	localparam longint unsigned MIN_SHORT_CYC = (MIN_SHORT_MS * CLOCK_HZ + 64'd999) / 64'd1000;
	localparam longint unsigned MIN_LONG_CYC = (MIN_LONG_MS * CLOCK_HZ + 64'd999) / 64'd1000;
	localparam longint unsigned MAX_HIGH_CYC = (MAX_HIGH_MS * CLOCK_HZ) / 64'd1000;

	// Register offsets
	localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
	localparam logic [ADDR_W-1:0] OFS_UPPER = 8'h04;
	localparam logic [ADDR_W-1:0] OFS_START = 8'h08;
	localparam logic [ADDR_W-1:0] OFS_COUNT = 8'h0C;
	localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h10;
	localparam logic [ADDR_W-1:0] OFS_MASK = 8'h14;

	// Control fields
	localparam int CTRL_UPPER_AUTO = 0;
	localparam int CTRL_LOWER_AUTO = 1;
	localparam int CTRL_ZERO_LONG = 2;
	localparam int CTRL_LOAD_LONG = 3;

	// Count register fields
	localparam int CNTREG_UPPER = 16;
	localparam int CNTREG_LOWER = 17;

	// Status and mask fields
	localparam int EV_UPPER = 0;
	localparam int EV_LOWER = 1;
	localparam int EV_ZERO = 2;
	localparam int EV_LOAD = 3;
	localparam int EV_REJECT = 4;

	// Qualifier channels
	localparam int CH_ZERO = 0;
	localparam int CH_LOAD = 1;

	// Reset values
	localparam logic [CTRL_W-1:0] CTRL_RST = 4'h3;
	localparam logic [COUNT_W-1:0] UPPER_RST = 16'h000A;
	localparam logic [COUNT_W-1:0] START_RST = 16'h0001;
	localparam logic [EV_W-1:0] MASK_RST = 5'h00;

	typedef enum logic [1:0]
	{
		Q_LOW = 2'b00,
		Q_HIGH = 2'b01,
		Q_LONG = 2'b10
	} q_phase_t;

	typedef struct packed
	{
		q_phase_t phase;
		logic [LEN_W-1:0] len;
		logic valid;
		logic reject;
	} qual_state_t;

	typedef struct packed
	{
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic wr;
		logic rd;
	} reg_req_t;

	typedef struct packed
	{
		logic count_up;
		logic count_down;
		logic zero_pulse;
		logic load_pulse;
	} count_in_t;

	typedef struct packed
	{
		logic [CTRL_W-1:0] ctrl;
		logic [COUNT_W-1:0] upper_thr;
		logic [COUNT_W-1:0] start_val;
		logic [COUNT_W-1:0] count;
		logic upper;
		logic lower;
		logic up_prev;
		logic down_prev;
		logic [EV_W-1:0] status;
		logic [EV_W-1:0] mask;
		logic irq;
		logic [DATA_W-1:0] rdata;
	} cnt_state_t;

endpackage

// ---- src/pulse_qualifier.sv ----
module pulse_qualifier
	import counter_pkg::*;
(
	input wire logic clock,
	input wire logic nrst,
	input wire logic ce,
	input wire logic level,
	input wire logic [LEN_W-1:0] min_cyc,
	input wire logic [LEN_W-1:0] max_cyc,
	output logic valid,
	output logic reject
);

	qual_state_t st;
	qual_state_t next_st;

	always_comb
	begin
		next_st = st;
		next_st.valid = 1'b0;
		next_st.reject = 1'b0;
		case (st.phase)
			Q_LOW:
			begin
				if (level)
				begin
					next_st.phase = Q_HIGH;
					next_st.len = LEN_W'(1);
				end
			end
			Q_HIGH:
			begin
				if (level)
				begin
					if (st.len >= max_cyc)
						next_st.phase = Q_LONG;
					else
						next_st.len = LEN_W'(st.len + LEN_W'(1));
				end
				else
				begin
					next_st.phase = Q_LOW;
					next_st.valid = (st.len >= min_cyc);
					next_st.reject = (st.len < min_cyc);
				end
			end
			Q_LONG:
			begin
				// Over-long pulse dropped at its falling edge
				if (!level)
				begin
					next_st.phase = Q_LOW;
					next_st.reject = 1'b1;
				end
			end
			default:
				next_st.phase = Q_LOW;
		endcase
	end

	always_ff @(posedge clock or negedge nrst)
	begin
		if (!nrst)
			st <= '{phase: Q_LOW, len: '0, valid: 1'b0, reject: 1'b0};
		else if (ce)
			st <= next_st;
	end

	assign valid = st.valid;
	assign reject = st.reject;

	property p_accept_window;
		@(posedge clock) disable iff (!nrst)
		ce && st.phase == Q_HIGH && !level && st.len >= min_cyc |=> valid && !reject;
	endproperty
	a_accept_window: assert property (p_accept_window) else $error("qualified pulse not accepted");

	property p_reject_long;
		@(posedge clock) disable iff (!nrst)
		ce && st.phase == Q_LONG && !level |=> reject && !valid;
	endproperty
	a_reject_long: assert property (p_reject_long) else $error("over-long pulse not rejected");

endmodule

// ---- src/up_down_event_counter.sv ----
// Function
// - Auto upper: one-cycle flag, then clear count
// - Manual upper: flag held, up counts ignored
// - Auto lower: one-cycle flag, then load start
// - Manual lower: flag held, down counts ignored
// - Reset/load beat counting; reset wins; flags low
// - Only rising input edges count
// - Flags rise in the cycle threshold reached
// - Up edge adds one, down subtracts one
// - Simultaneous up and down edges: no change
// - Control pulse valid only within width window
// - Valid load pulse sets count to start
//
// The register offsets and the address-and-strobe port were decided locally.
module up_down_event_counter
	import counter_pkg::*;
#(
	parameter longint unsigned MIN_SHORT_CYCLES = MIN_SHORT_CYC,
	parameter longint unsigned MIN_LONG_CYCLES = MIN_LONG_CYC,
	parameter longint unsigned MAX_HIGH_CYCLES = MAX_HIGH_CYC
)
(
	input wire logic clock,
	input wire logic nrst,
	input wire logic ce,
	input wire count_in_t count_in,
	input wire reg_req_t reg_req,
	output logic [DATA_W-1:0] rdata,
	output logic upper_flag,
	output logic lower_flag,
	output logic [COUNT_W-1:0] count_value,
	output logic irq
);

	cnt_state_t st;
	cnt_state_t next_st;
	logic [CHANNELS-1:0] ch_level;
	logic [CHANNELS-1:0] ch_long;
	logic [CHANNELS-1:0] ch_valid;
	logic [CHANNELS-1:0] ch_reject;
	logic up_e;
	logic down_e;
	logic zero_v;
	logic load_v;
	logic [EV_W-1:0] events;
	logic [EV_W-1:0] clear_bits;

	assign ch_level[CH_ZERO] = count_in.zero_pulse;
	assign ch_level[CH_LOAD] = count_in.load_pulse;
	assign ch_long[CH_ZERO] = st.ctrl[CTRL_ZERO_LONG];
	assign ch_long[CH_LOAD] = st.ctrl[CTRL_LOAD_LONG];

	genvar ch;
	generate
		for (ch = 0; ch < CHANNELS; ch++)
		begin : g_qual
			pulse_qualifier u_qual
			(
				.clock(clock),
				.nrst(nrst),
				.ce(ce),
				.level(ch_level[ch]),
				.min_cyc(ch_long[ch] ? LEN_W'(MIN_LONG_CYCLES) : LEN_W'(MIN_SHORT_CYCLES)),
				.max_cyc(LEN_W'(MAX_HIGH_CYCLES)),
				.valid(ch_valid[ch]),
				.reject(ch_reject[ch])
			);
		end
	endgenerate

	assign zero_v = ch_valid[CH_ZERO];
	assign load_v = ch_valid[CH_LOAD];
	assign up_e = count_in.count_up & ~st.up_prev;
	assign down_e = count_in.count_down & ~st.down_prev;

	always_comb
	begin
		next_st = st;
		next_st.up_prev = count_in.count_up;
		next_st.down_prev = count_in.count_down;
		// Manual flags stay while the count is untouched
		next_st.upper = st.upper & ~st.ctrl[CTRL_UPPER_AUTO];
		next_st.lower = st.lower & ~st.ctrl[CTRL_LOWER_AUTO];
		if (zero_v)
		begin
			next_st.count = '0;
			next_st.upper = 1'b0;
			next_st.lower = 1'b0;
		end
		else if (load_v)
		begin
			next_st.count = st.start_val;
			next_st.upper = 1'b0;
			next_st.lower = 1'b0;
		end
		else if (st.upper && st.ctrl[CTRL_UPPER_AUTO])
		begin
			next_st.count = '0;
			next_st.upper = 1'b0;
			next_st.lower = 1'b0;
		end
		else if (st.lower && st.ctrl[CTRL_LOWER_AUTO])
		begin
			next_st.count = st.start_val;
			next_st.upper = 1'b0;
			next_st.lower = 1'b0;
		end
		else if (up_e && down_e)
		begin
			next_st.count = st.count;
		end
		else if (up_e)
		begin
			if (st.count == st.upper_thr)
			begin
				// At threshold further up edges are absorbed
				next_st.upper = 1'b1;
			end
			else
			begin
				next_st.count = COUNT_W'(st.count + COUNT_W'(1));
				next_st.upper = (COUNT_W'(st.count + COUNT_W'(1)) == st.upper_thr);
				next_st.lower = 1'b0;
			end
		end
		else if (down_e)
		begin
			if (st.count == '0)
			begin
				next_st.lower = 1'b1;
			end
			else
			begin
				next_st.count = COUNT_W'(st.count - COUNT_W'(1));
				next_st.lower = (COUNT_W'(st.count - COUNT_W'(1)) == '0);
				next_st.upper = 1'b0;
			end
		end

		// Register writes
		clear_bits = '0;
		if (reg_req.wr)
		begin
			case (reg_req.addr)
				OFS_CTRL: next_st.ctrl = reg_req.wdata[CTRL_W-1:0];
				OFS_UPPER: next_st.upper_thr = reg_req.wdata[COUNT_W-1:0];
				OFS_START: next_st.start_val = reg_req.wdata[COUNT_W-1:0];
				OFS_STATUS: clear_bits = reg_req.wdata[EV_W-1:0];
				OFS_MASK: next_st.mask = reg_req.wdata[EV_W-1:0];
				default: clear_bits = '0;
			endcase
		end

		// Events; a set in the clear cycle survives
		events = '0;
		events[EV_UPPER] = next_st.upper & ~st.upper;
		events[EV_LOWER] = next_st.lower & ~st.lower;
		events[EV_ZERO] = zero_v;
		events[EV_LOAD] = load_v;
		events[EV_REJECT] = |ch_reject;
		next_st.status = (st.status & ~clear_bits) | events;
		next_st.irq = |(next_st.status & next_st.mask);

		// Read data one cycle after the strobe
		next_st.rdata = '0;
		if (reg_req.rd)
		begin
			case (reg_req.addr)
				OFS_CTRL: next_st.rdata = DATA_W'(st.ctrl);
				OFS_UPPER: next_st.rdata = DATA_W'(st.upper_thr);
				OFS_START: next_st.rdata = DATA_W'(st.start_val);
				OFS_COUNT:
				begin
					next_st.rdata = DATA_W'(st.count);
					next_st.rdata[CNTREG_UPPER] = st.upper;
					next_st.rdata[CNTREG_LOWER] = st.lower;
				end
				OFS_STATUS: next_st.rdata = DATA_W'(st.status);
				OFS_MASK: next_st.rdata = DATA_W'(st.mask);
				default: next_st.rdata = '0;
			endcase
		end
	end

	always_ff @(posedge clock or negedge nrst)
	begin
		if (!nrst)
		begin
			st <= '{ctrl: CTRL_RST, upper_thr: UPPER_RST, start_val: START_RST, count: '0,
				upper: 1'b0, lower: 1'b0, up_prev: 1'b0, down_prev: 1'b0,
				status: '0, mask: MASK_RST, irq: 1'b0, rdata: '0};
		end
		else if (ce)
		begin
			st <= next_st;
		end
	end

	assign rdata = st.rdata;
	assign upper_flag = st.upper;
	assign lower_flag = st.lower;
	assign count_value = st.count;
	assign irq = st.irq;

	sequence s_quiet;
		!zero_v && !load_v;
	endsequence

	sequence s_upper_auto_hit;
		(ce && st.upper && st.ctrl[CTRL_UPPER_AUTO]) and s_quiet;
	endsequence

	sequence s_lower_auto_hit;
		(ce && st.lower && st.ctrl[CTRL_LOWER_AUTO] && !(st.upper && st.ctrl[CTRL_UPPER_AUTO]))
		and s_quiet;
	endsequence

	property p_upper_auto;
		@(posedge clock) disable iff (!nrst)
		s_upper_auto_hit |=> !upper_flag && count_value == '0;
	endproperty
	a_upper_auto: assert property (p_upper_auto) else $error("auto upper did not clear");

	property p_upper_manual;
		@(posedge clock) disable iff (!nrst)
		(ce && st.upper && !st.ctrl[CTRL_UPPER_AUTO] && !down_e) and s_quiet
		|=> upper_flag && $stable(count_value);
	endproperty
	a_upper_manual: assert property (p_upper_manual) else $error("manual upper not held");

	property p_lower_auto;
		@(posedge clock) disable iff (!nrst)
		s_lower_auto_hit |=> !lower_flag && count_value == $past(st.start_val);
	endproperty
	a_lower_auto: assert property (p_lower_auto) else $error("auto lower did not load");

	property p_lower_manual;
		@(posedge clock) disable iff (!nrst)
		(ce && st.lower && !st.ctrl[CTRL_LOWER_AUTO] && !up_e) and s_quiet
		|=> lower_flag && count_value == '0;
	endproperty
	a_lower_manual: assert property (p_lower_manual) else $error("manual lower not held");

	property p_zero_wins;
		@(posedge clock) disable iff (!nrst)
		ce && zero_v |=> count_value == '0 && !upper_flag && !lower_flag;
	endproperty
	a_zero_wins: assert property (p_zero_wins) else $error("zero reset lost priority");

	property p_load;
		@(posedge clock) disable iff (!nrst)
		ce && load_v && !zero_v |=> count_value == $past(st.start_val) && !upper_flag && !lower_flag;
	endproperty
	a_load: assert property (p_load) else $error("start load failed");

	property p_no_edge;
		@(posedge clock) disable iff (!nrst)
		(ce && !up_e && !down_e && !st.upper && !st.lower) and s_quiet |=> $stable(count_value);
	endproperty
	a_no_edge: assert property (p_no_edge) else $error("count moved without edge");

	property p_up_step;
		@(posedge clock) disable iff (!nrst)
		(ce && up_e && !down_e && !st.upper && !st.lower && st.count != st.upper_thr) and s_quiet
		|=> count_value == COUNT_W'($past(st.count) + COUNT_W'(1));
	endproperty
	a_up_step: assert property (p_up_step) else $error("up edge did not add one");

	property p_both_edges;
		@(posedge clock) disable iff (!nrst)
		(ce && up_e && down_e && !st.upper && !st.lower) and s_quiet |=> $stable(count_value);
	endproperty
	a_both_edges: assert property (p_both_edges) else $error("dual edge changed count");

	property p_upper_same_cycle;
		@(posedge clock) disable iff (!nrst)
		(ce && up_e && !down_e && !st.upper && !st.lower
		&& COUNT_W'(st.count + COUNT_W'(1)) == st.upper_thr) and s_quiet |=> upper_flag;
	endproperty
	a_upper_same_cycle: assert property (p_upper_same_cycle) else $error("upper flag late");

	property p_upper_absorb;
		@(posedge clock) disable iff (!nrst)
		(ce && up_e && !down_e && !st.ctrl[CTRL_UPPER_AUTO] && !st.lower && st.count == st.upper_thr)
		and s_quiet |=> upper_flag && $stable(count_value);
	endproperty
	a_upper_absorb: assert property (p_upper_absorb) else $error("up edge at threshold not absorbed");

	property p_down_step;
		@(posedge clock) disable iff (!nrst)
		(ce && down_e && !up_e && !st.upper && !st.lower && st.count != '0) and s_quiet
		|=> count_value == COUNT_W'($past(st.count) - COUNT_W'(1));
	endproperty
	a_down_step: assert property (p_down_step) else $error("down edge did not subtract one");

	property p_lower_same_cycle;
		@(posedge clock) disable iff (!nrst)
		(ce && down_e && !up_e && !st.upper && !st.lower && st.count == COUNT_W'(1)) and s_quiet
		|=> lower_flag;
	endproperty
	a_lower_same_cycle: assert property (p_lower_same_cycle) else $error("lower flag late");

	property p_freeze;
		@(posedge clock) disable iff (!nrst)
		!ce |=> $stable(count_value) && $stable(upper_flag) && $stable(lower_flag);
	endproperty
	a_freeze: assert property (p_freeze) else $error("state moved while disabled");

endmodule

// ---- tb/input_source.sv ----
module input_source
	import counter_pkg::*;
(
	input wire logic clock,
	output count_in_t count_in
);
	timeunit 1ns;
	timeprecision 100ps;

	initial count_in = '0;

	// One-cycle high levels, so each call gives at most one rising edge per input
	task automatic edges(input logic up, input logic down);
		@(posedge clock);
		count_in.count_up <= up;
		count_in.count_down <= down;
		@(posedge clock);
		count_in.count_up <= 1'b0;
		count_in.count_down <= 1'b0;
	endtask

	// High for len logic cycles, then low
	task automatic pulse(input logic zero, input logic load, input int len);
		@(posedge clock);
		count_in.zero_pulse <= zero;
		count_in.load_pulse <= load;
		repeat (len) @(posedge clock);
		count_in.zero_pulse <= 1'b0;
		count_in.load_pulse <= 1'b0;
	endtask
endmodule

// ---- tb/up_down_event_counter_test.sv ----
module up_down_event_counter_test;
	import counter_pkg::*;
	timeunit 1ns;
	timeprecision 100ps;

	logic clock;
	logic nrst;
	logic ce;
	count_in_t count_in;
	reg_req_t reg_req;
	logic [DATA_W-1:0] rdata;
	logic upper_flag;
	logic lower_flag;
	logic [COUNT_W-1:0] count_value;
	logic irq;
	int bad_count;
	int cmp_count;
	int cycles;
	int seed;
	logic [31:0] got;
	logic [17:0] st;
	logic u;
	logic d;

	up_down_event_counter #(.MIN_SHORT_CYCLES(4), .MIN_LONG_CYCLES(8), .MAX_HIGH_CYCLES(40)) DUT (
		.clock(clock), .nrst(nrst), .ce(ce), .count_in(count_in), .reg_req(reg_req), .rdata(rdata),
		.upper_flag(upper_flag), .lower_flag(lower_flag), .count_value(count_value), .irq(irq));

	input_source src (.clock(clock), .count_in(count_in));

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic test_done;
		$display("checks %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	task automatic reg_wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge clock);
		reg_req.addr <= a;
		reg_req.wdata <= v;
		reg_req.wr <= 1'b1;
		@(posedge clock);
		reg_req.wr <= 1'b0;
	endtask

	task automatic reg_rd(input logic [7:0] a, output logic [31:0] v);
		@(posedge clock);
		reg_req.addr <= a;
		reg_req.rd <= 1'b1;
		@(posedge clock);
		reg_req.rd <= 1'b0;
		#1;
		v = rdata;
	endtask

	task automatic look(input logic [15:0] c, input logic uf, input logic lf);
		#1;
		check("count", {16'h0000, count_value}, {16'h0000, c});
		check("upper", {31'h0, upper_flag}, {31'h0, uf});
		check("lower", {31'h0, lower_flag}, {31'h0, lf});
	endtask

	// Manual modes: state is {lower, upper, count}
	function automatic logic [17:0] model(input logic [17:0] s, input logic up, input logic dn,
		input logic [15:0] thr);
		logic [15:0] c;
		c = s[15:0];
		if (up && !dn)
			return {1'b0, (c == thr) || (c + 16'h0001 == thr), (c == thr) ? c : c + 16'h0001};
		if (dn && !up)
			return {c <= 16'h0001, 1'b0, (c == 16'h0000) ? c : c - 16'h0001};
		return s;
	endfunction

	initial
	begin
		clock = 1'b0;
		forever #2.5 clock = ~clock;
	end

	always @(posedge clock)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			bad_count++;
			test_done();
		end
	end

	initial
	begin
		seed = 98245;
		nrst = 1'b0;
		reg_req = '0;
		ce = 1'b1;
		repeat (6) @(posedge clock);
		nrst <= 1'b1;
		reg_rd(OFS_CTRL, got);
		check("ctrl", got, 32'h00000003);
		reg_rd(OFS_UPPER, got);
		check("upper_thr", got, 32'h0000000A);
		reg_rd(OFS_START, got);
		check("start", got, 32'h00000001);
		reg_rd(OFS_MASK, got);
		check("mask", got, 32'h00000000);
		reg_wr(8'h18, 32'hFFFFFFFF);
		reg_rd(8'h18, got);
		check("unmapped", got, 32'h00000000);
		reg_wr(OFS_UPPER, 32'h00000002);
		src.edges(1'b1, 1'b0);
		look(16'h0001, 1'b0, 1'b0);
		src.edges(1'b1, 1'b0);
		look(16'h0002, 1'b1, 1'b0);
		@(posedge clock);
		look(16'h0000, 1'b0, 1'b0);
		src.edges(1'b1, 1'b0);
		src.edges(1'b0, 1'b1);
		look(16'h0000, 1'b0, 1'b1);
		@(posedge clock);
		look(16'h0001, 1'b0, 1'b0);
		reg_rd(OFS_STATUS, got);
		check("status", got, 32'h00000003);
		check("irq", {31'h0, irq}, 32'h0);
		reg_wr(OFS_MASK, 32'h00000013);
		@(posedge clock);
		#1;
		check("irq", {31'h0, irq}, 32'h1);
		reg_wr(OFS_STATUS, 32'h00000003);
		@(posedge clock);
		#1;
		check("irq", {31'h0, irq}, 32'h0);
		reg_wr(OFS_START, 32'h00000007);
		src.pulse(1'b1, 1'b0, 3);
		repeat (3) @(posedge clock);
		look(16'h0001, 1'b0, 1'b0);
		check("irq", {31'h0, irq}, 32'h1);
		src.pulse(1'b0, 1'b1, 4);
		repeat (3) @(posedge clock);
		look(16'h0007, 1'b0, 1'b0);
		src.pulse(1'b1, 1'b1, 40);
		repeat (3) @(posedge clock);
		look(16'h0000, 1'b0, 1'b0);
		src.pulse(1'b0, 1'b1, 41);
		repeat (3) @(posedge clock);
		look(16'h0000, 1'b0, 1'b0);
		reg_rd(OFS_STATUS, got);
		check("status", got, 32'h0000001C);
		// Long minimums on both control inputs
		reg_wr(OFS_CTRL, 32'h0000000C);
		src.pulse(1'b0, 1'b1, 8);
		repeat (3) @(posedge clock);
		look(16'h0007, 1'b0, 1'b0);
		src.pulse(1'b1, 1'b0, 6);
		repeat (3) @(posedge clock);
		look(16'h0007, 1'b0, 1'b0);
		reg_wr(OFS_START, 32'h00000003);
		src.pulse(1'b0, 1'b1, 7);
		repeat (3) @(posedge clock);
		look(16'h0007, 1'b0, 1'b0);
		reg_wr(OFS_CTRL, 32'h00000000);
		reg_wr(OFS_UPPER, 32'h00000004);
		src.pulse(1'b1, 1'b0, 4);
		repeat (3) @(posedge clock);
		look(16'h0000, 1'b0, 1'b0);
		st = '0;
		repeat (80)
		begin
			u = 1'($random(seed));
			d = 1'($random(seed));
			src.edges(u, d);
			st = model(st, u, d, 16'h0004);
			look(st[15:0], st[16], st[17]);
		end
		// Edge while disabled must not count
		@(posedge clock);
		ce <= 1'b0;
		src.edges(1'b1, 1'b0);
		look(st[15:0], st[16], st[17]);
		@(posedge clock);
		ce <= 1'b1;
		reg_rd(OFS_COUNT, got);
		check("count_reg", got, {14'h0, st});
		test_done();
	end
endmodule
